//--- flash_seq_pkg.sv
/*
 Shared constants and types of the serial flash program, erase and
 deep power-down sequencer. Assumes a 200 MHz core clock.
*/
package flash_seq_pkg;
   // ==========================================
   // Timing: times in microseconds, counts in core cycles.
   localparam int CLOCK_MHZ = 200;
   localparam int PROGRAM_TIME_US = 1000;
   localparam int ERASE_SECTOR_TIME_US = 100000;
   localparam int ERASE_CHIP_TIME_US = 1000000;
   localparam int POWERDOWN_ENTRY_TIME_US = 3;
   localparam int RELEASE_TIME_US = 3;
   localparam int TIMER_W = 32;
   // ==========================================
   // Opcodes.
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE_A = 8'hD8;
   localparam logic [7:0] OP_BLOCK_ERASE_B = 8'h52;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   // ==========================================
   // Frame lengths in whole bytes; data frames saturate at BYTES_DATA.
   localparam logic [2:0] BYTES_OPCODE = 3'h1;
   localparam logic [2:0] BYTES_ADDRESS = 3'h4;
   localparam logic [2:0] BYTES_DATA = 3'h5;
   // ==========================================
   // Array geometry and protection.
   localparam int PAGE_BITS = 8;
   localparam int PAGE_BYTES = 256;
   localparam int BLOCK_BITS = 16;
   localparam int BLOCK_SEL_BITS = 3;
   localparam logic [3:0] BLOCK_COUNT = 4'h8;
   localparam logic [2:0] PROTECT_ALL_LEVEL = 3'h4;
   localparam logic [23:0] SECTOR_BASE_MASK = 24'hFFF000;
   localparam logic [23:0] BLOCK_BASE_MASK = 24'hFF0000;
   localparam logic [1:0] ERASE_SECTOR = 2'h0;
   localparam logic [1:0] ERASE_BLOCK = 2'h1;
   localparam logic [1:0] ERASE_CHIP = 2'h2;
   // ==========================================
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE, ST_PROGRAM, ST_ERASE, ST_ENTRY, ST_DEEP, ST_WAKING
   } seq_state_type;
endpackage

//--- frame_link_if.sv
/*
 Carrier for the decoded serial frame from the link-clock shifter to the
 core sequencer. Fields change only on serial clock edges inside a frame.
*/
`timescale 1ns/10ps
interface frame_link_if;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [2:0] bit_count;
   logic [2:0] byte_count;
   logic [7:0] data;
   logic data_toggle;
   modport link (output opcode, addr, bit_count, byte_count, data, data_toggle);
   modport core (input opcode, addr, bit_count, byte_count, data, data_toggle);
endinterface

//--- host_spi_model.sv
/*
 Host serial controller model: shifts frames MSB first, clock parked low.
 Assumes the caller waits for each frame to finish.
*/
`timescale 1ns/10ps
module host_spi_model (
   // Serial link toward the device.
   output logic o_serial_clock,
   output logic o_chip_select_n,
   output logic o_serial_in
);
   // Idle: deselected, clock still.
   initial begin
      o_serial_clock = 1'b0;
      o_chip_select_n = 1'b1;
      o_serial_in = 1'b0;
   end
   // The gap comes first, so the caller times from the rise of chip select.
   task automatic send(input logic [63:0] f, input int n);
      #200 o_chip_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #31.25 o_serial_in = f[i];
         #31.25 o_serial_clock = 1'b1;
         #62.5 o_serial_clock = 1'b0;
      end
      #31.25 o_chip_select_n = 1'b1;
      // A released line shows the inverse, never a stale level.
      o_serial_in = ~o_serial_in;
   endtask
endmodule

//--- spi_flash_program_erase_powerdown.sv
/*
 Program, erase and deep power-down sequencer of a serial flash. Holds the
 page buffer and write enable latch, runs the self-timed cycles and drives
 a simple array write and erase port. Assumes the serial clock is much
 slower than the core clock and stands still while deselected.
// Contract
// - Page program needs the write enable latch set first.
// - Program data past page end wraps to the same page start.
// - Beyond 256 bytes only the last 256 are programmed.
// - Program frame must end on a byte boundary or is dropped.
// - Program cycle runs its time with write in progress high.
// - Write enable latch clears before any cycle completes.
// - Program into a protected page is not executed.
// - Sector erase needs the latch and wipes the addressed sector.
// - Erase frame is opcode plus address; any inner address selects.
// - Erase frame must end right after the last address byte.
// - Sector erase is timed, flagged busy, skipped when protected.
// - Either block opcode wipes the addressed 64 kilobyte block.
// - Block erase into a protected block is not executed.
// - Chip erase is the opcode alone, ending after its eighth bit.
// - Chip erase runs its time with write in progress high.
// - Chip erase only when all protect level bits are zero.
// - Deep sleep is its opcode alone, ending after eighth bit.
// - Deep sleep is entered only after the entry wait.
// - In deep sleep only the wake opcode is obeyed.
// - Deep sleep request during a busy cycle is ignored.
// - Deselect alone gives standby; reset starts in standby.
// - With the latch clear no program or erase is accepted.
// - Wake is the opcode alone; release wait before new commands.
*/
`timescale 1ns/10ps
module spi_flash_program_erase_powerdown import flash_seq_pkg::*; #(
   parameter int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ,
   parameter int ERASE_SECTOR_CYCLES = ERASE_SECTOR_TIME_US * CLOCK_MHZ,
   parameter int ERASE_CHIP_CYCLES = ERASE_CHIP_TIME_US * CLOCK_MHZ,
   parameter int ENTRY_CYCLES = POWERDOWN_ENTRY_TIME_US * CLOCK_MHZ,
   parameter int RELEASE_CYCLES = RELEASE_TIME_US * CLOCK_MHZ,
   parameter logic [7:0] OP_WRITE_ENABLE = 8'h06
) (
   // Core clock and reset.
   input wire logic i_clock,
   input wire logic i_srst,
   // Serial link from the host.
   input wire logic i_serial_clock,
   input wire logic i_chip_select_n,
   input wire logic i_serial_in,
   // Status register protect level, same clock domain.
   input wire logic [2:0] i_protect_level_bits,
   // Status.
   output logic o_write_in_progress,
   output logic o_write_enable_latch,
   output logic o_deep_power_down,
   // Array port.
   output logic o_array_write,
   output logic [23:0] o_array_addr,
   output logic [7:0] o_array_data,
   output logic o_array_erase,
   output logic [1:0] o_erase_size
);
   typedef struct packed {
      seq_state_type state;
      logic cs_meta;
      logic cs_sync;
      logic cs_prev;
      logic tog_meta;
      logic tog_sync;
      logic tog_prev;
      logic write_enable_latch;
      logic write_in_progress;
      logic deep;
      logic [TIMER_W-1:0] timer;
      logic [PAGE_BITS:0] walk;
      logic [PAGE_BITS-1:0] data_count;
      logic [23-PAGE_BITS:0] page_base;
      logic [PAGE_BYTES-1:0][7:0] page_data;
      logic [PAGE_BYTES-1:0] page_mask;
      logic array_write;
      logic [23:0] array_addr;
      logic [7:0] array_data;
      logic array_erase;
      logic [1:0] erase_size;
   } sys_state_type;

   sys_state_type st_ff;
   sys_state_type nxt_st;
   frame_link_if link ();
   logic frame_end;
   logic frame_start;
   logic byte_event;
   logic [PAGE_BITS-1:0] byte_index;
   logic [2:0] prot;

   // ==========================================
   // Link side shifter.
   spi_frame_shifter shifter (
      .i_serial_clock(i_serial_clock),
      .i_chip_select_n(i_chip_select_n),
      .i_serial_in(i_serial_in),
      .i_srst(i_srst),
      .o_link(link)
   );

   // ==========================================
   // Decoding helpers.
   // True when the frame held n whole bytes, or n or more when n is BYTES_DATA, where the byte count saturates.
   function automatic logic exact_len(input logic [2:0] n, input logic [2:0] bytes,
                                      input logic [2:0] bits);
      return (bytes == n) && (bits == 3'h0);
   endfunction

   // Upper blocks are protected; the count doubles per level up to all.
   function automatic logic is_protected(input logic [23:0] a, input logic [2:0] bp);
      logic [3:0] count;
      logic [3:0] block;
      count = (bp >= PROTECT_ALL_LEVEL) ? BLOCK_COUNT :
              (bp == 3'h0) ? 4'h0 : (4'h1 << (bp - 3'h1));
      block = {1'b0, a[BLOCK_BITS +: BLOCK_SEL_BITS]};
      return (block + count) >= BLOCK_COUNT;
   endfunction

   // Start a self-timed cycle: busy flag up, latch down at once.
   function automatic sys_state_type begin_cycle(input sys_state_type s,
                                                 input seq_state_type ns,
                                                 input int cycles);
      sys_state_type r;
      r = s;
      r.state = ns;
      r.write_in_progress = 1'b1;
      r.write_enable_latch = 1'b0;
      r.timer = TIMER_W'(cycles - 1);
      return r;
   endfunction

   // Frame edges seen after the two-stage synchronisers. Link fields are
   // read only once the frame has ended or a byte toggle has settled, so
   // they are quiet while sampled.
   // The select is stored active high, so the cleared reset value is idle.
   assign frame_end = !st_ff.cs_sync && st_ff.cs_prev;
   assign frame_start = st_ff.cs_sync && !st_ff.cs_prev;
   assign byte_event = st_ff.tog_sync != st_ff.tog_prev;
   assign byte_index = link.addr[PAGE_BITS-1:0] + st_ff.data_count;
   assign prot = i_protect_level_bits;

   // ==========================================
   // Next state.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cs_meta = !i_chip_select_n;
      nxt_st.cs_sync = st_ff.cs_meta;
      nxt_st.cs_prev = st_ff.cs_sync;
      nxt_st.tog_meta = link.data_toggle;
      nxt_st.tog_sync = st_ff.tog_meta;
      nxt_st.tog_prev = st_ff.tog_sync;
      nxt_st.array_write = 1'b0;
      nxt_st.array_erase = 1'b0;
      // The page buffer is only touched while idle, so status reads during
      // a cycle cannot disturb the walk.
      if (frame_start && st_ff.state == ST_IDLE) begin
         nxt_st.page_mask = '0;
         nxt_st.data_count = '0;
      end
      // Later bytes overwrite earlier ones at the wrapped index.
      if (byte_event && st_ff.state == ST_IDLE && link.opcode == OP_PAGE_PROGRAM) begin
         nxt_st.page_data[byte_index] = link.data;
         nxt_st.page_mask[byte_index] = 1'b1;
         nxt_st.data_count = st_ff.data_count + 8'h01;
      end
      case (st_ff.state)
         ST_IDLE: begin
            if (frame_end) begin
               case (link.opcode)
                  OP_WRITE_ENABLE: begin
                     if (exact_len(BYTES_OPCODE, link.byte_count, link.bit_count)) begin
                        nxt_st.write_enable_latch = 1'b1;
                     end
                  end
                  OP_PAGE_PROGRAM: begin
                     if (st_ff.write_enable_latch && exact_len(BYTES_DATA, link.byte_count, link.bit_count)
                         && !is_protected(link.addr, prot)) begin
                        nxt_st = begin_cycle(nxt_st, ST_PROGRAM, PROGRAM_CYCLES);
                        nxt_st.walk = '0;
                        nxt_st.page_base = link.addr[23:PAGE_BITS];
                     end
                  end
                  OP_SECTOR_ERASE: begin
                     if (st_ff.write_enable_latch && exact_len(BYTES_ADDRESS, link.byte_count, link.bit_count)
                         && !is_protected(link.addr, prot)) begin
                        nxt_st = begin_cycle(nxt_st, ST_ERASE, ERASE_SECTOR_CYCLES);
                        nxt_st.array_erase = 1'b1;
                        nxt_st.erase_size = ERASE_SECTOR;
                        nxt_st.array_addr = link.addr & SECTOR_BASE_MASK;
                     end
                  end
                  OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B: begin
                     if (st_ff.write_enable_latch && exact_len(BYTES_ADDRESS, link.byte_count, link.bit_count)
                         && !is_protected(link.addr, prot)) begin
                        nxt_st = begin_cycle(nxt_st, ST_ERASE, ERASE_SECTOR_CYCLES);
                        nxt_st.array_erase = 1'b1;
                        nxt_st.erase_size = ERASE_BLOCK;
                        nxt_st.array_addr = link.addr & BLOCK_BASE_MASK;
                     end
                  end
                  OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                     if (st_ff.write_enable_latch && exact_len(BYTES_OPCODE, link.byte_count, link.bit_count)
                         && prot == 3'h0) begin
                        nxt_st = begin_cycle(nxt_st, ST_ERASE, ERASE_CHIP_CYCLES);
                        nxt_st.array_erase = 1'b1;
                        nxt_st.erase_size = ERASE_CHIP;
                        nxt_st.array_addr = '0;
                     end
                  end
                  OP_DEEP_SLEEP: begin
                     if (exact_len(BYTES_OPCODE, link.byte_count, link.bit_count)) begin
                        nxt_st.state = ST_ENTRY;
                        nxt_st.timer = TIMER_W'(ENTRY_CYCLES - 1);
                     end
                  end
                  default: begin
                     nxt_st.state = ST_IDLE;
                  end
               endcase
            end
         end
         // Busy states ignore every frame, deep sleep requests included.
         ST_PROGRAM: begin
            if (!st_ff.walk[PAGE_BITS]) begin
               // Only bytes that arrived are written; the rest stay intact.
               nxt_st.array_write = st_ff.page_mask[st_ff.walk[PAGE_BITS-1:0]];
               nxt_st.array_addr = {st_ff.page_base, st_ff.walk[PAGE_BITS-1:0]};
               nxt_st.array_data = st_ff.page_data[st_ff.walk[PAGE_BITS-1:0]];
               nxt_st.walk = st_ff.walk + 9'h001;
            end
            nxt_st.timer = st_ff.timer - TIMER_W'(1);
            if (st_ff.timer == '0 && st_ff.walk[PAGE_BITS]) begin
               nxt_st.state = ST_IDLE;
               nxt_st.write_in_progress = 1'b0;
            end
         end
         ST_ERASE: begin
            nxt_st.timer = st_ff.timer - TIMER_W'(1);
            if (st_ff.timer == '0) begin
               nxt_st.state = ST_IDLE;
               nxt_st.write_in_progress = 1'b0;
            end
         end
         // Frames during the entry wait are ignored; only the timer runs.
         ST_ENTRY: begin
            nxt_st.timer = st_ff.timer - TIMER_W'(1);
            if (st_ff.timer == '0) begin
               nxt_st.state = ST_DEEP;
               nxt_st.deep = 1'b1;
            end
         end
         ST_DEEP: begin
            if (frame_end && link.opcode == OP_WAKE
                && exact_len(BYTES_OPCODE, link.byte_count, link.bit_count)) begin
               nxt_st.state = ST_WAKING;
               nxt_st.timer = TIMER_W'(RELEASE_CYCLES - 1);
            end
         end
         // Frames during release are ignored; the host must stay deselected.
         ST_WAKING: begin
            nxt_st.timer = st_ff.timer - TIMER_W'(1);
            if (st_ff.timer == '0) begin
               nxt_st.state = ST_IDLE;
               nxt_st.deep = 1'b0;
            end
         end
         default: begin
            nxt_st.state = ST_IDLE;
         end
      endcase
   end

   // Reset lands in standby with the latch and busy flag clear.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================
   // Outputs straight from the state register.
   assign o_write_in_progress = st_ff.write_in_progress;
   assign o_write_enable_latch = st_ff.write_enable_latch;
   assign o_deep_power_down = st_ff.deep;
   assign o_array_write = st_ff.array_write;
   assign o_array_addr = st_ff.array_addr;
   assign o_array_data = st_ff.array_data;
   assign o_array_erase = st_ff.array_erase;
   assign o_erase_size = st_ff.erase_size;

   // ==========================================
   // Assertions.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   sequence s_end_in_idle;
      frame_end && st_ff.state == ST_IDLE;
   endsequence
   sequence s_program_req;
      s_end_in_idle ##0 link.opcode == OP_PAGE_PROGRAM;
   endsequence
   property p_program_needs_latch;
      s_program_req ##0 !st_ff.write_enable_latch |=> st_ff.state == ST_IDLE && !o_write_in_progress;
   endproperty
   a_program_needs_latch: assert property (p_program_needs_latch)
      else $error("program started without write enable latch");
   property p_program_whole_bytes;
      s_program_req ##0 link.bit_count != 3'h0 |=> !o_write_in_progress;
   endproperty
   a_program_whole_bytes: assert property (p_program_whole_bytes)
      else $error("program ran after a partial byte");
   property p_program_runs;
      s_program_req ##0 (st_ff.write_enable_latch && link.byte_count == BYTES_DATA && link.bit_count == 3'h0
         && !is_protected(link.addr, prot)) |=> o_write_in_progress [*2];
   endproperty
   a_program_runs: assert property (p_program_runs)
      else $error("valid program did not raise write in progress");
   property p_latch_drops;
      $rose(o_write_in_progress) |-> !o_write_enable_latch;
   endproperty
   a_latch_drops: assert property (p_latch_drops)
      else $error("write enable latch still set during a cycle");
   property p_page_wrap;
      o_array_write |-> o_write_in_progress && o_array_addr[23:PAGE_BITS] == st_ff.page_base;
   endproperty
   a_page_wrap: assert property (p_page_wrap)
      else $error("program write left its page");
   property p_chip_protected;
      s_end_in_idle ##0 (link.opcode == OP_CHIP_ERASE_A || link.opcode == OP_CHIP_ERASE_B)
         && prot != 3'h0 |=> !o_array_erase && !o_write_in_progress;
   endproperty
   a_chip_protected: assert property (p_chip_protected)
      else $error("chip erase ran with protection set");
   property p_erase_unprotected;
      o_array_erase && o_erase_size != ERASE_CHIP |->
         !is_protected(o_array_addr, $past(i_protect_level_bits));
   endproperty
   a_erase_unprotected: assert property (p_erase_unprotected)
      else $error("erase issued into a protected area");
   property p_busy_ignores_sleep;
      frame_end && o_write_in_progress |=> st_ff.state != ST_ENTRY;
   endproperty
   a_busy_ignores_sleep: assert property (p_busy_ignores_sleep)
      else $error("deep sleep accepted during a busy cycle");
   property p_deep_blocks_array;
      o_deep_power_down |-> !o_array_write && !o_array_erase && !o_write_in_progress;
   endproperty
   a_deep_blocks_array: assert property (p_deep_blocks_array)
      else $error("array activity while in deep sleep");
   property p_entry_wait;
      $rose(o_deep_power_down) |-> $past(st_ff.state) == ST_ENTRY && $past(st_ff.timer) == '0;
   endproperty
   a_entry_wait: assert property (p_entry_wait)
      else $error("deep sleep entered before the entry wait ended");
   property p_cycle_ends_on_time;
      $fell(o_write_in_progress) |-> $past(st_ff.timer) == '0;
   endproperty
   a_cycle_ends_on_time: assert property (p_cycle_ends_on_time)
      else $error("busy flag fell before the cycle time ran out");
endmodule

//--- spi_frame_shifter.sv
/*
 Serial input shifter on the link clock. Counts bits and whole bytes of a
 frame and captures opcode, address and each data byte. Assumes the serial
 clock stands still while chip select is high.
*/
`timescale 1ns/10ps
module spi_frame_shifter import flash_seq_pkg::*; (
   // Link clock and frame.
   input wire logic i_serial_clock,
   input wire logic i_chip_select_n,
   input wire logic i_serial_in,
   // Core reset, applied only while the link is idle.
   input wire logic i_srst,
   // Decoded frame.
   frame_link_if.link o_link
);
   typedef struct packed {
      logic [2:0] bit_count;
      logic [2:0] byte_count;
      logic [6:0] shift;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
      logic toggle;
   } link_state_type;

   link_state_type st_ff;
   link_state_type nxt_st;
   logic armed_ff;

   // ==========================================
   // Frame arming: deselect marks the next edge as the first of a frame.
   // Counts survive deselect so the core can read them afterwards.
   always_ff @(posedge i_serial_clock or posedge i_chip_select_n) begin
      if (i_chip_select_n) begin
         armed_ff <= 1'b1;
      end else begin
         armed_ff <= 1'b0;
      end
   end

   // Shift one bit; route each finished byte by its place in the frame.
   always_comb begin
      nxt_st = st_ff;
      if (armed_ff) begin
         nxt_st = '0;
         nxt_st.toggle = st_ff.toggle;
      end
      if (nxt_st.bit_count == 3'h7) begin
         if (nxt_st.byte_count == 3'h0) begin
            nxt_st.opcode = {nxt_st.shift, i_serial_in};
         end else if (nxt_st.byte_count < BYTES_ADDRESS) begin
            nxt_st.addr = {nxt_st.addr[15:0], nxt_st.shift, i_serial_in};
         end else begin
            nxt_st.data = {nxt_st.shift, i_serial_in};
            nxt_st.toggle = ~nxt_st.toggle;
         end
         if (nxt_st.byte_count != BYTES_DATA) begin
            nxt_st.byte_count = nxt_st.byte_count + 3'h1;
         end
      end
      nxt_st.shift = {nxt_st.shift[5:0], i_serial_in};
      nxt_st.bit_count = nxt_st.bit_count + 3'h1;
   end

   // The toggle must never be cleared per frame, so only reset clears it.
   always_ff @(posedge i_serial_clock or posedge i_srst) begin
      if (i_srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_link.opcode = st_ff.opcode;
   assign o_link.addr = st_ff.addr;
   assign o_link.bit_count = st_ff.bit_count;
   assign o_link.byte_count = st_ff.byte_count;
   assign o_link.data = st_ff.data;
   assign o_link.data_toggle = st_ff.toggle;
endmodule

//--- tb_top.sv
/*
 Self-checking bench of the flash sequencer.
 Assumes the host model owns the link; the bench drives protect bits.
*/
`timescale 1ns/10ps
module tb_top import flash_seq_pkg::*; ;
   // ==========================================
   // Setup. Cycle counts are shortened; frames still fit inside PC, SC and CC, but not inside WC.
   localparam int PC = 2000;
   localparam int SC = 2000;
   localparam int CC = 3000;
   localparam int WC = 20;
   logic i_clock, i_srst, i_serial_clock, i_chip_select_n, i_serial_in;
   logic [2:0] i_protect_level_bits;
   logic o_write_in_progress, o_write_enable_latch, o_deep_power_down, o_array_write, o_array_erase;
   logic [23:0] o_array_addr, a, d;
   logic [7:0] o_array_data;
   logic [1:0] o_erase_size;
   logic [7:0] ops[3] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B};
   logic [23:0] wa[$];
   logic [7:0] wd[$];
   int errors = 0, tests_run = 0, n_er = 0, len = 0, last_len = 0, ne;
   int seed = 87543;
   host_spi_model i_host_spi_model (.o_serial_clock(i_serial_clock), .o_chip_select_n(i_chip_select_n),
      .o_serial_in(i_serial_in));
   spi_flash_program_erase_powerdown #(.PROGRAM_CYCLES(PC), .ERASE_SECTOR_CYCLES(SC), .ERASE_CHIP_CYCLES(CC),
      .ENTRY_CYCLES(WC), .RELEASE_CYCLES(WC)) i_spi_flash_program_erase_powerdown (.i_clock, .i_srst,
      .i_serial_clock, .i_chip_select_n, .i_serial_in, .i_protect_level_bits, .o_write_in_progress,
      .o_write_enable_latch, .o_deep_power_down, .o_array_write, .o_array_addr, .o_array_data,
      .o_array_erase, .o_erase_size);
   // Core clock, 5 ns.
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   // Watches the one-cycle array pulses and how long busy stands.
   always @(posedge i_clock) begin
      if (o_array_write === 1'b1) begin
         wa.push_back(o_array_addr);
         wd.push_back(o_array_data);
      end
      if (o_array_erase === 1'b1) n_er++;
      if (o_write_in_progress === 1'b1) len++;
      else if (len > 0) begin
         last_len = len;
         len = 0;
      end
   end
   // ==========================================
   // Tasks and expectations.
   function automatic logic [23:0] base_of(input logic [23:0] x, input logic [1:0] sz);
      return x & ((sz == ERASE_SECTOR) ? SECTOR_BASE_MASK : BLOCK_BASE_MASK);
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic send(input logic [63:0] f, input int n);
      i_host_spi_model.send(f, n);
      st(10);
   endtask
   task automatic idle(input int b);
      int n;
      n = 0;
      while (o_write_in_progress !== 1'b0 && n < b) begin
         @(posedge i_clock);
         n++;
      end
      // One more edge lets the busy-length monitor settle before it is read.
      st(1);
      if (n >= b) begin
         errors++;
         final_report();
      end
   endtask
   task automatic cmd(input logic [63:0] f, input int n, input logic run, input logic [1:0] sz,
      input logic [23:0] x, input int cyc);
      int e0;
      send(64'h06, 8);
      e0 = n_er;
      send(f, n);
      chk(o_write_in_progress, run);
      chk(24'(n_er - e0), run);
      if (run) begin
         chk(o_write_enable_latch, 1'b0);
         chk(o_erase_size, sz);
         if (sz != ERASE_CHIP) chk(o_array_addr, base_of(x, sz));
         idle(cyc + 50);
         chk(last_len >= cyc - 1 && last_len <= cyc + 1, 1'b1);
      end
   endtask
   // ==========================================
   // Main sequence.
   initial begin
      i_srst = 1'b1;
      i_protect_level_bits = 3'h0;
      st(12);
      i_srst <= 1'b0;
      st(3);
      chk({o_deep_power_down, o_write_in_progress, o_write_enable_latch}, 3'h0);
      a = $random(seed);
      d = $random(seed);
      a[7:0] = 8'hFE;
      send({8'h0, OP_PAGE_PROGRAM, a, d}, 56);
      chk(o_write_in_progress, 1'b0);
      send(64'h06, 8);
      chk(o_write_enable_latch, 1'b1);
      send({8'h0, OP_PAGE_PROGRAM, a, d}, 56);
      chk(o_write_in_progress, 1'b1);
      chk(o_write_enable_latch, 1'b0);
      idle(PC + 300);
      chk(last_len >= PC - 1 && last_len <= PC + 1, 1'b1);
      chk(24'(wa.size()), 24'h3);
      // The walk writes in page order, so the wrapped third byte comes first.
      for (int k = 0; k < 3; k++) begin
         chk(wa[k], {a[23:8], a[7:0] + 8'((k + 2) % 3)});
         chk(wd[k], d[23 - 8 * ((k + 2) % 3) -: 8]);
      end
      $display("test program done");
      cmd({8'h0, OP_PAGE_PROGRAM, a, d} >> 14, 42, 1'b0, 2'h0, a, 0);
      cmd({24'h0, OP_SECTOR_ERASE, a, 8'hA5}, 40, 1'b0, 2'h0, a, 0);
      cmd({55'h0, OP_CHIP_ERASE_A, 1'b1}, 9, 1'b0, 2'h0, a, 0);
      for (int k = 0; k < 3; k++) begin
         a = $random(seed);
         cmd({32'h0, ops[k], a}, 32, 1'b1, (k == 0) ? ERASE_SECTOR : ERASE_BLOCK, a, SC);
      end
      cmd({56'h0, OP_CHIP_ERASE_A}, 8, 1'b1, ERASE_CHIP, a, CC);
      cmd({56'h0, OP_CHIP_ERASE_B}, 8, 1'b1, ERASE_CHIP, a, CC);
      i_protect_level_bits <= PROTECT_ALL_LEVEL;
      cmd({32'h0, OP_SECTOR_ERASE, a}, 32, 1'b0, 2'h0, a, 0);
      cmd({32'h0, OP_BLOCK_ERASE_A, a}, 32, 1'b0, 2'h0, a, 0);
      cmd({8'h0, OP_PAGE_PROGRAM, a, d}, 56, 1'b0, 2'h0, a, 0);
      i_protect_level_bits <= 3'h1;
      cmd({56'h0, OP_CHIP_ERASE_B}, 8, 1'b0, 2'h0, a, 0);
      i_protect_level_bits <= 3'h0;
      $display("test erase done");
      send({56'h0, OP_CHIP_ERASE_A}, 8);
      ne = n_er;
      send({56'h0, OP_DEEP_SLEEP}, 8);
      send(64'h06, 8);
      send({32'h0, OP_SECTOR_ERASE, a}, 32);
      idle(CC);
      st(WC + 10);
      chk(o_deep_power_down, 1'b0);
      chk(24'(n_er - ne), 24'h0);
      send({55'h0, OP_DEEP_SLEEP, 1'b0}, 9);
      st(WC + 10);
      chk(o_deep_power_down, 1'b0);
      send({56'h0, OP_DEEP_SLEEP}, 8);
      chk(o_deep_power_down, 1'b0);
      st(WC);
      chk(o_deep_power_down, 1'b1);
      send(64'h06, 8);
      chk(o_write_enable_latch, 1'b0);
      send({56'h0, OP_WAKE}, 8);
      chk(o_deep_power_down, 1'b1);
      st(WC);
      chk(o_deep_power_down, 1'b0);
      $display("test sleep done");
      final_report();
   end
   // Hang guard, about 100000 core cycles.
   initial begin
      #500000;
      errors++;
      final_report();
   end
endmodule
